// file: include/rtwm_pkg.sv
// constants for the two-wire bus master that drives the clock/calendar part
// assumes a 100 MHz core clock and an open-drain bus with external pull-ups
package rtwm_pkg;
   localparam logic [3:0] RTWM_CODE_EEPROM = 4'b1010;
   localparam logic [3:0] RTWM_CODE_CLOCK = 4'b1101;
   localparam logic [2:0] RTWM_SELECT_BITS = 3'b111;
   localparam logic RTWM_DIR_READ = 1'b1;
   localparam logic RTWM_DIR_WRITE = 1'b0;
   localparam int RTWM_CORE_MHZ = 100;
   localparam int RTWM_HALF_NS = 2500;
   localparam int RTWM_HALF_CYC = (RTWM_HALF_NS * RTWM_CORE_MHZ + 999) / 1000;
   localparam int RTWM_BUF_NS = 4700;
   localparam int RTWM_BUF_CYC = (RTWM_BUF_NS * RTWM_CORE_MHZ + 999) / 1000;
   localparam logic [7:0] RTWM_CLOCK_LAST = 8'h5f;
   localparam logic [7:0] RTWM_SRAM_FIRST = 8'h20;
   localparam logic [7:0] RTWM_REG_LAST = 8'h1f;
   typedef enum logic [6:0] {
      RTWM_IDLE = 7'b000_0001,
      RTWM_START = 7'b000_0010,
      RTWM_BYTE = 7'b000_0100,
      RTWM_ACK = 7'b000_1000,
      RTWM_WAIT = 7'b001_0000,
      RTWM_STOP = 7'b010_0000,
      RTWM_BUF = 7'b100_0000
   } rtwm_state_e;
endpackage

// file: include/rtwm_pin_if.sv
// carrier between the sequencer and its line sampler
// assumes both ends run on core_clk
`timescale 1ns/10ps
`default_nettype none
interface rtwm_pin_if;
   logic scl_s;
   logic sda_s;
   modport sampler (output scl_s, output sda_s);
   modport user (input scl_s, input sda_s);
endinterface
`default_nettype wire

// file: rtl/rtwm_sync.sv
// two-flop synchroniser for the bus lines as seen on the wire
// assumes raw inputs are asynchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module rtwm_sync (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   rtwm_pin_if.sampler pins
);
   logic [1:0] scl_r;
   logic [1:0] sda_r;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         scl_r <= 2'h3;
         sda_r <= 2'h3;
      end else begin
         scl_r <= {scl_r[0], scl_in};
         sda_r <= {sda_r[0], sda_in};
      end
   end
   assign pins.scl_s = scl_r[1];
   assign pins.sda_s = sda_r[1];
endmodule
`default_nettype wire

// file: rtl/rtwm_master.sv
// byte-level two-wire master: start, control byte, data bytes, stop
// assumes pull-ups on both lines; user issues one byte per request
`timescale 1ns/10ps
`default_nettype none
module rtwm_master
   import rtwm_pkg::*;
#(
   parameter int HALF_CYC = RTWM_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_start,
   input wire logic req_eeprom,
   input wire logic req_read,
   input wire logic req_control,
   input wire logic req_last,
   input wire logic [7:0] req_data,
   output logic rsp_valid,
   output logic rsp_nack,
   output logic [7:0] rsp_data,
   output logic busy
);
   // the tick counter is 16 bits wide and every phase needs at least two counts
   if (HALF_CYC < 2 || HALF_CYC > 65535) begin : g_half_chk
      $error("rtwm_master: HALF_CYC out of range");
   end

   rtwm_pin_if pins ();
   rtwm_sync u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .pins(pins.sampler)
   );

   rtwm_state_e state_r;
   logic [15:0] tick_r;
   logic [1:0] phase_r;
   logic [3:0] bit_r;
   logic [7:0] shift_r;
   logic [7:0] rx_r;
   logic rd_r;
   logic last_r;
   logic scl_low_r;
   logic sda_low_r;
   logic open_r;
   logic tick_done;
   logic shift_is_ctrl_r;
   logic ctrl_read_r;

   assign tick_done = (tick_r == 16'(HALF_CYC - 1));
   // open drain: drive only a low level
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_low_r;
   assign sda_oe = sda_low_r;
   assign req_ready = (state_r == RTWM_IDLE || state_r == RTWM_WAIT) && !rsp_valid;
   assign busy = open_r;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tick_r <= 16'h0000;
      end else if (state_r == RTWM_IDLE || state_r == RTWM_WAIT || tick_done) begin
         tick_r <= 16'h0000;
      end else if (!(phase_r == 2'h2 && !pins.scl_s)) begin
         // clock stretching: hold the high phase until the line is really high
         tick_r <= tick_r + 16'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= RTWM_IDLE;
         phase_r <= 2'h0;
         bit_r <= 4'h0;
         shift_r <= 8'h00;
         rx_r <= 8'h00;
         rd_r <= 1'b0;
         last_r <= 1'b0;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         open_r <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_nack <= 1'b0;
         rsp_data <= 8'h00;
      end else begin
         rsp_valid <= 1'b0;
         unique case (state_r)
            RTWM_IDLE, RTWM_WAIT: begin
               if (req_valid && req_ready) begin
                  last_r <= req_last;
                  phase_r <= 2'h0;
                  bit_r <= 4'h0;
                  if (req_control) begin
                     shift_r <= {req_eeprom ? RTWM_CODE_EEPROM : RTWM_CODE_CLOCK,
                                 RTWM_SELECT_BITS,
                                 req_read ? RTWM_DIR_READ : RTWM_DIR_WRITE};
                     rd_r <= 1'b0;
                  end else begin
                     shift_r <= req_data;
                  end
                  if (req_start || !open_r) begin
                     state_r <= open_r ? RTWM_START : RTWM_BUF;
                     if (req_control) begin
                        rd_r <= 1'b0;
                     end
                  end else begin
                     state_r <= RTWM_BYTE;
                  end
               end
            end
            RTWM_BUF: begin
               // wait for a free bus: both lines high when a count of HALF_CYC ends
               if (!(pins.scl_s && pins.sda_s)) begin
                  state_r <= RTWM_BUF;
               end else if (tick_done) begin
                  state_r <= RTWM_START;
               end
            end
            RTWM_START: begin
               if (tick_done) begin
                  phase_r <= phase_r + 2'h1;
                  unique case (phase_r)
                     2'h0: begin
                        sda_low_r <= 1'b0;
                        scl_low_r <= 1'b1;
                     end
                     2'h1: scl_low_r <= 1'b0;
                     2'h2: sda_low_r <= 1'b1;
                     default: begin
                        scl_low_r <= 1'b1;
                        open_r <= 1'b1;
                        state_r <= RTWM_BYTE;
                     end
                  endcase
               end
            end
            RTWM_BYTE, RTWM_ACK: begin
               if (tick_done) begin
                  phase_r <= phase_r + 2'h1;
                  unique case (phase_r)
                     2'h0: begin
                        // data set up in the low phase
                        if (state_r == RTWM_BYTE) begin
                           sda_low_r <= !rd_r && !shift_r[7];
                        end else begin
                           sda_low_r <= rd_r && !last_r;
                        end
                     end
                     2'h1: scl_low_r <= 1'b0;
                     2'h2: begin
                        if (state_r == RTWM_BYTE) begin
                           rx_r <= {rx_r[6:0], pins.sda_s};
                        end else if (!rd_r) begin
                           rsp_nack <= pins.sda_s;
                        end else begin
                           rsp_nack <= 1'b0;
                        end
                     end
                     default: begin
                        scl_low_r <= 1'b1;
                        if (state_r == RTWM_BYTE) begin
                           shift_r <= {shift_r[6:0], 1'b0};
                           bit_r <= bit_r + 4'h1;
                           if (bit_r == 4'h7) begin
                              state_r <= RTWM_ACK;
                           end
                        end else begin
                           rsp_valid <= 1'b1;
                           rsp_data <= rx_r;
                           // data is kept as it is: letting it rise as the clock falls
                           // could be taken for a stop; the next low phase sets it
                           // a nack to a written byte ends the operation, reads never
                           if ((!rd_r && rsp_nack) || last_r) begin
                              state_r <= RTWM_STOP;
                           end else begin
                              state_r <= RTWM_WAIT;
                           end
                        end
                     end
                  endcase
               end
            end
            RTWM_STOP: begin
               if (tick_done) begin
                  phase_r <= phase_r + 2'h1;
                  unique case (phase_r)
                     2'h0: sda_low_r <= 1'b1;
                     2'h1: scl_low_r <= 1'b0;
                     2'h2: sda_low_r <= 1'b0;
                     default: begin
                        open_r <= 1'b0;
                        state_r <= RTWM_IDLE;
                     end
                  endcase
               end
            end
            default: state_r <= RTWM_IDLE;
         endcase
         // direction latched once the control byte has been acknowledged
         if (state_r == RTWM_ACK && tick_done && phase_r == 2'h3 && shift_is_ctrl_r) begin
            rd_r <= ctrl_read_r;
         end
      end
   end

   // control byte direction tracking: read data begins after its ack
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         shift_is_ctrl_r <= 1'b0;
         ctrl_read_r <= 1'b0;
      end else if ((state_r == RTWM_IDLE || state_r == RTWM_WAIT) && req_valid && req_ready) begin
         shift_is_ctrl_r <= req_control;
         ctrl_read_r <= req_control && req_read;
      end
   end

endmodule
`default_nettype wire

// file: tb/rtwm_monitor.sv
// checks on the master's bus pins and responses
// assumes binding into rtwm_master with HALF_CYC from 4 to 14
`timescale 1ns/10ps
`default_nettype none
module rtwm_monitor (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic rsp_valid,
   input wire logic rsp_nack,
   input wire logic busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic [3:0] puls_r;
   // a repeated start releases the clock once more, so a start clears the count
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) puls_r <= 4'h0;
      else if (rsp_valid || ($rose(sda_oe) && scl_in)) puls_r <= 4'h0;
      else if ($fell(scl_oe)) puls_r <= puls_r + 4'h1;
   end
   property p_low; $rose(scl_oe) |-> scl_oe[*3]; endproperty
   a_low: assert property (p_low) else $error("short low");
   property p_high; $fell(scl_oe) && busy |-> !scl_oe[*3]; endproperty
   a_high: assert property (p_high) else $error("short high");
   property p_start; $rose(sda_oe) && !scl_oe && scl_in |=> !scl_oe[*2] ##[1:20] scl_oe;
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   property p_stop; $fell(sda_oe) && !scl_oe && scl_in |-> ##[0:40] !busy; endproperty
   a_stop: assert property (p_stop) else $error("bad stop");
   // a fresh start must find both lines high just before data is pulled down
   property p_idle; $rose(sda_oe) && scl_in && !busy |->
      $past(scl_in) && $past(sda_in);
   endproperty
   a_idle: assert property (p_idle) else $error("busy bus");
   property p_nine; rsp_valid && !rsp_nack |-> puls_r == 4'h9; endproperty
   a_nine: assert property (p_nine) else $error("bit count");
   property p_nack; rsp_valid && rsp_nack |-> ##[0:60] !busy; endproperty
   a_nack: assert property (p_nack) else $error("no stop");
   property p_pulse; rsp_valid |=> !rsp_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("long pulse");
   c_ack: cover property (rsp_valid && !rsp_nack);
   c_nack: cover property (rsp_valid && rsp_nack);
   c_end: cover property ($fell(busy));
endmodule
bind rtwm_master rtwm_monitor rtwm_monitor_i (.core_clk, .resetn, .scl_in, .sda_in,
   .scl_oe, .sda_oe, .rsp_valid, .rsp_nack, .busy);
`default_nettype wire

// file: tb/rtwm_dev_model.sv
// behavioural clock/calendar slave on the resolved bus lines
// assumes pull-ups outside; event driven, read data counts up from 8'h3c
`timescale 1ns/10ps
`default_nettype none
module rtwm_dev_model
   import rtwm_pkg::*;
(
   input wire logic scl,
   input wire logic sda,
   input wire logic ee_busy,
   input wire logic backup,
   input wire logic event_src,
   output logic dev_oe,
   output logic [7:0] last_wr,
   output logic multifunction_output_pin
);
   // configuration register of the clock space: level bit 7, wave and alarm enables 6..4
   localparam logic [7:0] CFG_ADDR = 8'h07;
   logic [7:0] sh_r = 8'h00;
   logic [7:0] rdv_r = 8'h3c;
   logic [7:0] ptr_r = 8'h00;
   logic [7:0] cfg_r = 8'h00;
   logic act_r = 1'b0;
   logic rd_r = 1'b0;
   logic ctl_r = 1'b0;
   logic clk_sp = 1'b0;
   logic adr_ph = 1'b0;
   int n = 0;
   initial dev_oe = 1'b0;
   // event_src stands for the alarm or square-wave source once either is enabled
   assign multifunction_output_pin = (|cfg_r[6:4]) ? event_src : cfg_r[7];
   // on backup supply no start is ever seen, so the port stays silent
   always @(negedge sda) if (scl && !backup) begin
      {act_r, ctl_r, rd_r} = 3'h6;
      n = 0;
   end
   always @(posedge sda) if (scl) {act_r, dev_oe} = 2'h0;
   always @(posedge scl) if (act_r) begin
      if (n < 8) sh_r = {sh_r[6:0], sda};
      else if (rd_r && sda) act_r = 1'b0;
      n++;
   end
   always @(negedge scl) begin
      if (n == 9) n = 0;
      if (!act_r) dev_oe = 1'b0;
      else if (n == 8 && !rd_r && ctl_r) begin
         dev_oe = sh_r[7:1] == {4'hd, 3'h7} || (!ee_busy && sh_r[7:1] == {4'ha, 3'h7});
         {act_r, rd_r, ctl_r, adr_ph} = {dev_oe, sh_r[0], 1'b0, 1'b1};
         clk_sp = sh_r[7:4] == 4'hd;
      end else if (n == 8 && !rd_r) begin
         last_wr = sh_r;
         // past the sram the clock space has no location, so such an address is refused
         dev_oe = !(adr_ph && clk_sp && sh_r > RTWM_CLOCK_LAST);
         act_r = dev_oe;
         if (adr_ph) ptr_r = sh_r;
         else begin
            if (clk_sp && ptr_r == CFG_ADDR) cfg_r = sh_r;
            ptr_r = ptr_r + 8'h01;
         end
         adr_ph = 1'b0;
      end else if (rd_r) begin
         dev_oe = n < 8 ? !rdv_r[7 - n] : 1'b0;
         if (n == 8) rdv_r = rdv_r + 8'h01;
      end else dev_oe = 1'b0;
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench: the master against a behavioural slave
// assumes pull-ups on both lines, resolved here as a wired and
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
   logic core_clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, ee_busy = 1'b0, backup = 1'b0;
   logic req_start = 1'b0, req_eeprom = 1'b0, req_read = 1'b0, req_control = 1'b0;
   logic req_last = 1'b0;
   logic [7:0] req_data = 8'h00;
   logic scl_out, scl_oe, sda_out, sda_oe, req_ready, rsp_valid, rsp_nack, busy, dev_oe;
   logic [7:0] rsp_data, last_wr;
   logic event_src = 1'b0, pin_level;
   int num_errors = 0, tests_run = 0, cyc = 0;
   wire scl_in = scl_oe ? scl_out : 1'b1;
   wire sda_in = (sda_oe ? sda_out : 1'b1) & !dev_oe;
   rtwm_master #(.HALF_CYC(4)) rtwm_master_i (.core_clk, .resetn, .scl_in, .scl_out, .scl_oe,
      .sda_in, .sda_out, .sda_oe, .req_valid, .req_ready, .req_start, .req_eeprom, .req_read,
      .req_control, .req_last, .req_data, .rsp_valid, .rsp_nack, .rsp_data, .busy);
   rtwm_dev_model rtwm_dev_model_i (.scl(scl_in), .sda(sda_in), .ee_busy, .backup, .dev_oe,
      .last_wr, .event_src, .multifunction_output_pin(pin_level));
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) if (++cyc == 20000) begin
      num_errors++;
      wrap_up();
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ready is looked at on the falling edge, so the taking edge is never in doubt
   task automatic xfer(input logic st, ee, rd, ctl, last, input logic [7:0] d);
      int n;
      @(negedge core_clk);
      {req_start, req_eeprom, req_read, req_control, req_last} = {st, ee, rd, ctl, last};
      req_data = d;
      req_valid = 1'b1;
      for (n = 0; n < 2000 && !req_ready; n++) @(negedge core_clk);
      @(negedge core_clk);
      req_valid = 1'b0;
      for (n = 0; n < 2000 && !rsp_valid; n++) @(negedge core_clk);
      `CHK("answer", 1'b1, rsp_valid)
   endtask
   task automatic idle_chk();
      int n;
      for (n = 0; n < 200 && busy; n++) @(negedge core_clk);
      `CHK("busy", 1'b0, busy)
      `CHK("drive levels", 2'h0, {scl_out, sda_out})
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      xfer(1, 0, 0, 1, 0, 8'h00);
      xfer(0, 0, 0, 0, 0, a);
      xfer(0, 0, 0, 0, 1, d);
   endtask
   task automatic t_range();
      xfer(1, 0, 0, 1, 0, 8'h00);
      xfer(0, 0, 0, 0, 0, 8'h60);
      `CHK("range nack", 1'b1, rsp_nack)
      idle_chk();
      xfer(1, 0, 0, 1, 0, 8'h00);
      xfer(0, 0, 0, 0, 1, 8'h5f);
      `CHK("range top ack", 1'b0, rsp_nack)
      idle_chk();
   endtask
   task automatic t_pin();
      wr_reg(8'h07, 8'h80);
      `CHK("pin level high", 1'b1, pin_level)
      wr_reg(8'h07, 8'h10);
      `CHK("pin alarm low", 1'b0, pin_level)
      event_src = 1'b1;
      @(negedge core_clk);
      `CHK("pin alarm high", 1'b1, pin_level)
      event_src = 1'b0;
      wr_reg(8'h07, 8'h00);
      `CHK("pin level low", 1'b0, pin_level)
      idle_chk();
   endtask
   task automatic t_write();
      xfer(1, 0, 0, 1, 0, 8'h00);
      `CHK("control nack", 1'b0, rsp_nack)
      xfer(0, 0, 0, 0, 0, 8'h21);
      xfer(0, 0, 0, 0, 1, 8'h5a);
      `CHK("data nack", 1'b0, rsp_nack)
      `CHK("byte seen", 8'h5a, last_wr)
      idle_chk();
   endtask
   task automatic t_read();
      xfer(1, 0, 0, 1, 0, 8'h00);
      xfer(0, 0, 0, 0, 0, 8'h20);
      xfer(1, 0, 1, 1, 0, 8'h00);
      `CHK("read control nack", 1'b0, rsp_nack)
      xfer(0, 0, 1, 0, 0, 8'h00);
      `CHK("read byte", 8'h3c, rsp_data)
      xfer(0, 0, 1, 0, 1, 8'h00);
      `CHK("last byte", 8'h3d, rsp_data)
      idle_chk();
   endtask
   task automatic t_refuse();
      ee_busy = 1'b1;
      xfer(1, 1, 0, 1, 1, 8'h00);
      `CHK("busy memory nack", 1'b1, rsp_nack)
      xfer(1, 0, 0, 1, 1, 8'h00);
      `CHK("clock space nack", 1'b0, rsp_nack)
      ee_busy = 1'b0;
      backup = 1'b1;
      xfer(1, 0, 0, 1, 1, 8'h00);
      `CHK("backup nack", 1'b1, rsp_nack)
      backup = 1'b0;
      xfer(1, 1, 0, 1, 1, 8'h00);
      `CHK("memory nack", 1'b0, rsp_nack)
      idle_chk();
   endtask
   initial begin
      repeat (12) @(negedge core_clk);
      resetn = 1'b1;
      t_write();
      t_read();
      t_refuse();
      t_range();
      t_pin();
      wrap_up();
   end
endmodule
`default_nettype wire
